// file: cic_controller.sv
/*
  Cascaded pair of interrupt controllers with per-line edge/level control.
  Assumes the host issues single-cycle I/O read/write strobes on the system
  clock and a one-cycle interrupt acknowledge pulse; request lines are async.
*/
`timescale 1ns/1ps

module cic_unit
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register access
  input wire cic_io_t i_io,
  input wire logic i_trig_wr,
  // Requests and acknowledge
  input wire logic [7:0] i_irq,
  input wire logic i_ack,
  // Outputs
  output logic [7:0] o_rdata,
  output logic [7:0] o_trig,
  output logic [7:0] o_vector,
  output cic_grant_t o_grant,
  output logic o_int,
  output logic [7:0] o_cascade,
  output logic o_buf_en
);
  cic_init_t init_state;
  logic [7:0] mask;
  logic [7:0] irr;
  logic [7:0] isr;
  logic [7:0] trig;
  logic [7:0] irq_prev;
  logic [4:0] vec_base;
  logic [7:0] cascade;
  logic level_mode;
  logic need_four;
  logic sfnm;
  logic auto_eoi;
  logic [1:0] buf_mode;
  logic rot_aeoi;
  logic [2:0] lowest;
  logic smm;
  logic read_is;
  logic poll;
  logic [7:0] line_level;
  logic [7:0] edge_seen;
  logic [7:0] req;
  logic [2:0] top_req;
  logic req_found;
  logic [2:0] top_is;
  logic is_found;
  logic [7:0] eoi_clear;
  logic [7:0] ack_set;
  logic even_wr;
  logic odd_wr;
  logic word_one;

  assign even_wr = i_io.wr && !i_io.odd;
  assign odd_wr = i_io.wr && i_io.odd;
  assign word_one = even_wr && i_io.data[B_INIT_ONE];

  // Per-line trigger selection
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_line
      // Level line is held; edge line latches a rising transition
      assign edge_seen[g] = i_irq[g] && !irq_prev[g];
      assign line_level[g] = (trig[g] || level_mode) ? i_irq[g] : edge_seen[g];
    end
  endgenerate

  // Pending requests that may win: mask, and in-service lines of equal/lower rank
  function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
    rank = 3'(lvl - low - 3'h1);
  endfunction

  always_comb
  begin
    logic [2:0] best_r;
    logic [2:0] is_r;
    logic [2:0] r;
    best_r = 3'h7;
    is_r = 3'h7;
    r = 3'h0;
    req_found = 1'b0;
    is_found = 1'b0;
    top_req = 3'h0;
    top_is = 3'h0;
    req = irr & ~mask;
    for (int k = 0; k < 8; k++)
    begin
      r = rank(3'(k), lowest);
      if (isr[k] && (!is_found || r < is_r) && !(smm && mask[k]))
      begin
        is_r = r;
        top_is = 3'(k);
        is_found = 1'b1;
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      r = rank(3'(k), lowest);
      if (req[k] && (!req_found || r < best_r))
      begin
        best_r = r;
        top_req = 3'(k);
        req_found = 1'b1;
      end
    end
    // In special mask mode an in-service line blocks the grant only when it is itself the top pending request
    if (req_found && is_found && !smm)
    begin
      // special fully nested lets a cascade line reinterrupt itself
      if (best_r > is_r || (best_r == is_r && !(sfnm && cascade[top_req])))
      begin
        req_found = 1'b0;
      end
    end
    if (req_found && smm && isr[top_req])
    begin
      req_found = 1'b0;
    end
  end

  // End-of-interrupt clear vector
  always_comb
  begin
    eoi_clear = ZERO8;
    if (even_wr && !word_one && i_io.data[4:3] == SEL_OP_TWO && init_state == CIC_READY)
    begin
      case (i_io.data[7:5])
        CMD_NS_EOI, CMD_ROT_NS_EOI: if (is_found) eoi_clear[top_is] = 1'b1;
        CMD_SP_EOI, CMD_ROT_SP_EOI: eoi_clear[i_io.data[2:0]] = 1'b1;
        default: eoi_clear = ZERO8;
      endcase
    end
  end

  always_comb
  begin
    ack_set = ZERO8;
    if (i_ack && req_found)
    begin
      ack_set[top_req] = 1'b1;
    end
  end

  // Initialization sequence
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      init_state <= CIC_READY;
      level_mode <= 1'b0;
      need_four <= 1'b0;
      vec_base <= 5'h00;
      cascade <= ZERO8;
      sfnm <= 1'b0;
      auto_eoi <= 1'b0;
      buf_mode <= 2'h0;
    end
    else if (word_one)
    begin
      init_state <= CIC_WAIT_TWO;
      level_mode <= i_io.data[B_LEVEL_MODE];
      need_four <= i_io.data[B_NEED_FOUR];
      sfnm <= 1'b0;
      auto_eoi <= 1'b0;
    end
    else if (odd_wr)
    begin
      case (init_state)
        CIC_WAIT_TWO:
        begin
          vec_base <= i_io.data[7:3];
          init_state <= CIC_WAIT_THREE;
        end
        CIC_WAIT_THREE:
        begin
          cascade <= i_io.data;
          init_state <= need_four ? CIC_WAIT_FOUR : CIC_READY;
        end
        CIC_WAIT_FOUR:
        begin
          sfnm <= i_io.data[B_SFNM];
          buf_mode <= i_io.data[B_BUF:B_BUF - 1];
          auto_eoi <= i_io.data[B_AUTO_EOI];
          init_state <= CIC_READY;
        end
        default: init_state <= CIC_READY;
      endcase
    end
  end

  // Mask register
  always_ff @(posedge i_clk)
  begin
    if (i_rst || word_one)
    begin
      mask <= (i_rst) ? MASK_RESET : ZERO8;
    end
    else if (odd_wr && init_state == CIC_READY)
    begin
      mask <= i_io.data;
    end
  end

  // Edge/level register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      trig <= ZERO8;
    end
    else if (i_trig_wr)
    begin
      trig <= i_io.data;
    end
  end

  // Request and in-service state; new requests win over acknowledge clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_prev <= ZERO8;
      irr <= ZERO8;
      isr <= ZERO8;
    end
    else
    begin
      irq_prev <= i_irq;
      for (int k = 0; k < 8; k++)
      begin
        if (line_level[k])
        begin
          irr[k] <= 1'b1;
        end
        else if (ack_set[k] || (!i_irq[k] && (trig[k] || level_mode)))
        begin
          irr[k] <= 1'b0;
        end
      end
      if (word_one)
      begin
        isr <= ZERO8;
      end
      else
      begin
        isr <= (isr & ~eoi_clear) | (auto_eoi ? ZERO8 : ack_set);
      end
    end
  end

  // Operation words: priority, special mask, read select, poll
  always_ff @(posedge i_clk)
  begin
    if (i_rst || word_one)
    begin
      rot_aeoi <= 1'b0;
      lowest <= LOWEST_RESET;
      smm <= 1'b0;
      read_is <= 1'b0;
      poll <= 1'b0;
    end
    else
    begin
      if (even_wr && init_state == CIC_READY && i_io.data[4:3] == SEL_OP_TWO)
      begin
        case (i_io.data[7:5])
          CMD_ROT_AEOI_SET: rot_aeoi <= 1'b1;
          CMD_ROT_AEOI_CLR: rot_aeoi <= 1'b0;
          CMD_ROT_NS_EOI: if (is_found) lowest <= top_is;
          CMD_ROT_SP_EOI, CMD_SET_PRIO: lowest <= i_io.data[2:0];
          default: lowest <= lowest;
        endcase
      end
      else if (i_ack && req_found && auto_eoi && rot_aeoi)
      begin
        lowest <= top_req;
      end
      if (even_wr && init_state == CIC_READY && i_io.data[4:3] == SEL_OP_THREE)
      begin
        if (i_io.data[B_SMM_EN])
        begin
          smm <= i_io.data[B_SMM_VAL];
        end
        if (i_io.data[B_READ_EN])
        begin
          read_is <= i_io.data[B_READ_IS];
        end
        poll <= i_io.data[B_POLL];
      end
      else if (i_io.rd && !i_io.odd)
      begin
        poll <= 1'b0;
      end
    end
  end

  // Register read data and acknowledge vector
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= ZERO8;
      o_vector <= ZERO8;
    end
    else
    begin
      if (i_io.odd)
      begin
        o_rdata <= mask;
      end
      else if (poll)
      begin
        o_rdata <= req_found ? (POLL_FLAG | {5'h00, top_req}) : POLL_NONE;
      end
      else
      begin
        o_rdata <= read_is ? isr : irr;
      end
      if (i_ack)
      begin
        o_vector <= {vec_base, top_req};
      end
    end
  end

  assign o_trig = trig;
  assign o_grant = '{valid: req_found, level: top_req};
  assign o_int = req_found && init_state == CIC_READY;
  assign o_cascade = cascade;
  assign o_buf_en = buf_mode[1];
endmodule

module cic_controller
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // I/O cycle from the host
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt request lines 0-15
  input wire logic [15:0] i_irq,
  // Interrupt acknowledge
  input wire logic i_inta,
  output logic o_intr,
  output logic [7:0] o_vector,
  output logic o_buf_en
);
  logic [15:0] irq_meta;
  logic [15:0] irq_sync;
  logic pri_sel;
  logic sec_sel;
  cic_io_t pri_io;
  cic_io_t sec_io;
  logic [7:0] pri_rdata;
  logic [7:0] sec_rdata;
  logic [7:0] pri_trig;
  logic [7:0] sec_trig;
  logic [7:0] pri_vec;
  logic [7:0] sec_vec;
  logic [7:0] pri_casc;
  logic [7:0] sec_casc;
  cic_grant_t pri_grant;
  logic sec_int;
  logic pri_buf;
  logic sec_buf;
  logic pri_ack;
  logic sec_ack;
  logic use_sec;
  logic [7:0] pri_irq;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_meta <= 16'h0000;
      irq_sync <= 16'h0000;
    end
    else
    begin
      irq_meta <= i_irq;
      irq_sync <= irq_meta;
    end
  end

  assign pri_sel = i_addr == PORT_PRI_EVEN || i_addr == PORT_PRI_ODD;
  assign sec_sel = i_addr == PORT_SEC_EVEN || i_addr == PORT_SEC_ODD;
  assign pri_io = '{wr: i_wr && pri_sel, rd: i_rd && pri_sel, odd: i_addr[0], data: i_wdata};
  assign sec_io = '{wr: i_wr && sec_sel, rd: i_rd && sec_sel, odd: i_addr[0], data: i_wdata};

  // Secondary output feeds the primary cascade input
  assign pri_irq = {irq_sync[7:3], sec_int, irq_sync[1:0]};
  // Secondary answers when its identity matches the granted primary line
  assign use_sec = pri_casc[pri_grant.level] && sec_casc[2:0] == pri_grant.level;
  assign pri_ack = i_inta;
  assign sec_ack = i_inta && use_sec;

  cic_unit u_pri (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_io(pri_io),
    .i_trig_wr(i_wr && i_addr == PORT_TRIG_PRI),
    .i_irq(pri_irq),
    .i_ack(pri_ack),
    .o_rdata(pri_rdata),
    .o_trig(pri_trig),
    .o_vector(pri_vec),
    .o_grant(pri_grant),
    .o_int(o_intr),
    .o_cascade(pri_casc),
    .o_buf_en(pri_buf)
  );

  cic_unit u_sec (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_io(sec_io),
    .i_trig_wr(i_wr && i_addr == PORT_TRIG_SEC),
    .i_irq(irq_sync[15:8]),
    .i_ack(sec_ack),
    .o_rdata(sec_rdata),
    .o_trig(sec_trig),
    .o_vector(sec_vec),
    .o_grant(),
    .o_int(sec_int),
    .o_cascade(sec_casc),
    .o_buf_en(sec_buf)
  );

  logic vec_from_sec;
  logic [15:0] rd_addr;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      vec_from_sec <= 1'b0;
      rd_addr <= 16'h0000;
    end
    else
    begin
      rd_addr <= i_addr;
      if (i_inta)
      begin
        vec_from_sec <= use_sec;
      end
    end
  end

  always_comb
  begin
    case (rd_addr)
      PORT_PRI_EVEN, PORT_PRI_ODD: o_rdata = pri_rdata;
      PORT_SEC_EVEN, PORT_SEC_ODD: o_rdata = sec_rdata;
      PORT_TRIG_PRI: o_rdata = pri_trig;
      PORT_TRIG_SEC: o_rdata = sec_trig;
      default: o_rdata = ZERO8;
    endcase
  end

  assign o_vector = vec_from_sec ? sec_vec : pri_vec;
  assign o_buf_en = pri_buf || sec_buf;
endmodule

// file: cic_pkg.sv
/*
  Package for the cascaded interrupt controller pair: I/O port addresses,
  command word field positions, command codes and shared types.
  Assumes an 8-bit I/O data path and a 16-bit I/O address.
*/
package cic_pkg;

  // I/O port addresses
  localparam logic [15:0] PORT_PRI_EVEN = 16'h0020;
  localparam logic [15:0] PORT_PRI_ODD = 16'h0021;
  localparam logic [15:0] PORT_SEC_EVEN = 16'h00a0;
  localparam logic [15:0] PORT_SEC_ODD = 16'h00a1;
  localparam logic [15:0] PORT_TRIG_PRI = 16'h04d0;
  localparam logic [15:0] PORT_TRIG_SEC = 16'h04d1;

  // Field positions
  localparam int B_INIT_ONE = 4;
  localparam int B_LEVEL_MODE = 3;
  localparam int B_NEED_FOUR = 0;
  localparam int B_SFNM = 4;
  localparam int B_AUTO_EOI = 1;
  localparam int B_BUF = 3;
  localparam int B_POLL = 2;
  localparam int B_READ_EN = 1;
  localparam int B_READ_IS = 0;
  localparam int B_SMM_EN = 6;
  localparam int B_SMM_VAL = 5;

  // Selector field bits 4-3 of an even-port write
  localparam logic [1:0] SEL_OP_TWO = 2'h0;
  localparam logic [1:0] SEL_OP_THREE = 2'h1;

  // Operation word two commands, bits 7-5
  localparam logic [2:0] CMD_ROT_AEOI_CLR = 3'h0;
  localparam logic [2:0] CMD_NS_EOI = 3'h1;
  localparam logic [2:0] CMD_SP_EOI = 3'h3;
  localparam logic [2:0] CMD_ROT_AEOI_SET = 3'h4;
  localparam logic [2:0] CMD_ROT_NS_EOI = 3'h5;
  localparam logic [2:0] CMD_SET_PRIO = 3'h6;
  localparam logic [2:0] CMD_ROT_SP_EOI = 3'h7;

  // Values after reset and poll answer codes
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [2:0] LOWEST_RESET = 3'h7;
  localparam logic [7:0] POLL_NONE = 8'h00;
  localparam logic [7:0] POLL_FLAG = 8'h80;

  // Cascade input of the primary
  localparam int CASCADE_LINE = 2;

  typedef enum logic [1:0] {CIC_READY, CIC_WAIT_TWO, CIC_WAIT_THREE, CIC_WAIT_FOUR}
    cic_init_t;

  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } cic_grant_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic odd;
    logic [7:0] data;
  } cic_io_t;

endpackage

// file: cic_checker_sva.sv
/*
  Port checker for cic_controller: register readback, init gating, vectors.
  Assumes one-cycle strobes and a read taken two edges after a write.
*/
`timescale 1ns/1ps
module cic_checker
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host side
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_inta,
  input wire logic o_intr,
  input wire logic [7:0] o_vector,
  input wire logic o_buf_en
);
  logic [2:0] pri_step;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Primary init progress: 1-3 awaiting odd words, 4 ready
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pri_step <= 3'h0;
    else if (i_wr && i_addr == PORT_PRI_EVEN && i_wdata[B_INIT_ONE])
      pri_step <= 3'h1;
    else if (i_wr && i_addr == PORT_PRI_ODD && pri_step != 3'h0 && pri_step != 3'h4)
      pri_step <= pri_step + 3'h1;
  end
  sequence s_wr_rd(a);
    i_wr && i_addr == a ##2 i_rd && i_addr == a;
  endsequence
  sequence s_poll_rd;
    i_wr && i_addr == PORT_PRI_EVEN && i_wdata[4:3] == SEL_OP_THREE && i_wdata[B_POLL]
      ##2 i_rd && i_addr == PORT_PRI_EVEN;
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) i_rst |=> o_intr == 1'b0 && o_vector == 8'h00;
  endproperty
  property p_init_gate;
    o_intr |-> pri_step == 3'h4;
  endproperty
  property p_restart;
    i_wr && i_addr == PORT_PRI_EVEN && i_wdata[B_INIT_ONE] |=> !o_intr [*3];
  endproperty
  property p_mask_rdbk;
    pri_step == 3'h4 ##0 s_wr_rd(PORT_PRI_ODD) |=> o_rdata == $past(i_wdata, 3);
  endproperty
  property p_trig_rdbk;
    s_wr_rd(PORT_TRIG_SEC) |=> o_rdata == $past(i_wdata, 3);
  endproperty
  property p_buf_cause;
    $rose(o_buf_en) |-> $past(i_wr) && $past(i_addr[0]);
  endproperty
  property p_poll;
    pri_step == 3'h4 ##0 s_poll_rd |=> o_rdata[6:3] == 4'h0;
  endproperty
  property p_vec_hold;
    !i_inta |=> $stable(o_vector);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  a_init_gate: assert property (p_init_gate) else $error("interrupt before init done");
  a_restart: assert property (p_restart) else $error("interrupt kept after first word");
  a_mask_rdbk: assert property (p_mask_rdbk) else $error("mask readback wrong");
  a_trig_rdbk: assert property (p_trig_rdbk) else $error("trigger readback wrong");
  a_buf_cause: assert property (p_buf_cause) else $error("buffer enable without odd write");
  a_poll: assert property (p_poll) else $error("poll answer malformed");
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved without ack");
endmodule

bind cic_controller cic_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_inta(i_inta),
  .o_intr(o_intr), .o_vector(o_vector), .o_buf_en(o_buf_en));

// file: cic_host.sv
/*
  Host processor model: I/O writes, reads, acknowledges and init sequences.
  Assumes the controller takes strobes at a rising edge and answers next cycle.
*/
`timescale 1ns/1ps
module cic_host
  import cic_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // I/O cycle
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata,
  // Acknowledge
  output logic o_inta,
  input wire logic [7:0] i_vector
);
  initial
  begin
    o_addr = 16'h0000;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_inta = 1'b0;
  end
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // Released data does not keep its last value
    o_wdata <= ~d;
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    // Take the answer once it has settled, away from the edge that updates it
    @(negedge i_clk);
    d = i_rdata;
  endtask
  task automatic ack(output logic [7:0] v);
    @(posedge i_clk);
    o_inta <= 1'b1;
    @(posedge i_clk);
    o_inta <= 1'b0;
    @(posedge i_clk);
    v = i_vector;
  endtask
  task automatic init(input logic [15:0] ev, input logic [7:0] base, c3, c4);
    io_wr(ev, 8'h11);
    io_wr(ev + 16'h1, base);
    io_wr(ev + 16'h1, c3);
    io_wr(ev + 16'h1, c4);
  endtask
endmodule

// file: cic_controller_test.sv
/*
  Self-checking bench for cic_controller with the host model on its I/O side.
  Assumes the bound checker watches the design's ports.
*/
`timescale 1ns/1ps
module cic_controller_test
  import cic_pkg::*;
;
  logic clk = 1'b0;
  logic rst;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [15:0] irq;
  logic inta;
  logic intr;
  logic [7:0] vector;
  logic buf_en;
  logic [7:0] d;
  int errors = 0;
  int checks = 0;
  // Request line beside the vector it should give
  logic [11:0] rows [15] = '{12'h008, 12'h109, 12'h30b, 12'h40c, 12'h50d, 12'h60e, 12'h70f,
    12'h870, 12'h971, 12'ha72, 12'hb73, 12'hc74, 12'hd75, 12'he76, 12'hf77};
  always #4 clk = ~clk;
  cic_controller dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_irq(irq), .i_inta(inta), .o_intr(intr),
    .o_vector(vector), .o_buf_en(buf_en));
  cic_host host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata), .o_inta(inta), .i_vector(vector));
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic grab(input logic [7:0] exp);
    logic [7:0] v;
    int n;
    n = 0;
    while (intr !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    host.ack(v);
    chk(v, exp);
  endtask
  task automatic serve(input logic [7:0] exp);
    grab(exp);
    if (exp[7:3] == 5'h0e)
      host.io_wr(PORT_SEC_EVEN, 8'h20);
    host.io_wr(PORT_PRI_EVEN, 8'h20);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    irq = 16'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    host.io_rd(PORT_PRI_ODD, d);
    chk(d, MASK_RESET);
    host.io_rd(PORT_TRIG_PRI, d);
    chk(d, 8'h00);
    host.io_rd(16'h0022, d);
    chk(d, 8'h00);
    host.io_wr(PORT_TRIG_SEC, 8'ha5);
    host.io_rd(PORT_TRIG_SEC, d);
    chk(d, 8'ha5);
    host.io_wr(PORT_TRIG_SEC, 8'h00);
    // Low base bits are written nonzero (101 and 111) and must not reach the vector
    host.init(PORT_PRI_EVEN, 8'h0d, 8'h04, 8'h01);
    host.init(PORT_SEC_EVEN, 8'h77, 8'h02, 8'h01);
    foreach (rows[i])
    begin
      @(posedge clk);
      irq[rows[i][11:8]] <= 1'b1;
      serve(rows[i][7:0]);
      irq <= 16'h0000;
    end
    @(posedge clk);
    irq <= 16'h022a;
    serve(8'h09);
    serve(8'h71);
    serve(8'h0b);
    serve(8'h0d);
    irq <= 16'h0000;
    host.io_wr(PORT_PRI_EVEN, 8'hc4);
    @(posedge clk);
    irq <= 16'h0028;
    serve(8'h0d);
    serve(8'h0b);
    irq <= 16'h0000;
    host.io_wr(PORT_PRI_EVEN, 8'hc7);
    @(posedge clk);
    irq <= 16'h0010;
    grab(8'h0c);
    @(posedge clk);
    irq <= 16'h0050;
    repeat (4) @(posedge clk);
    chk({7'h00, intr}, 8'h00);
    host.io_wr(PORT_PRI_EVEN, 8'h0b);
    host.io_rd(PORT_PRI_EVEN, d);
    chk(d, 8'h10);
    host.io_wr(PORT_PRI_EVEN, 8'h64);
    serve(8'h0e);
    irq <= 16'h0000;
    host.io_wr(PORT_PRI_ODD, 8'h80);
    host.io_rd(PORT_PRI_ODD, d);
    chk(d, 8'h80);
    @(posedge clk);
    irq <= 16'h0080;
    repeat (4) @(posedge clk);
    chk({7'h00, intr}, 8'h00);
    host.io_wr(PORT_PRI_ODD, 8'h00);
    host.io_wr(PORT_PRI_EVEN, 8'h0c);
    host.io_rd(PORT_PRI_EVEN, d);
    chk(d, 8'h87);
    // Serve the unmasked line so the restart begins with nothing pending
    serve(8'h0f);
    irq <= 16'h0000;
    // Mid-run restart with a new base and buffered primary
    host.init(PORT_PRI_EVEN, 8'h40, 8'h04, 8'h0d);
    @(posedge clk);
    chk({7'h00, buf_en}, 8'h01);
    irq <= 16'h0081;
    grab(8'h40);
    // Rotating end-of-interrupt makes line 0 the lowest
    host.io_wr(PORT_PRI_EVEN, 8'ha0);
    serve(8'h47);
    irq <= 16'h0000;
    @(posedge clk);
    irq <= 16'h0003;
    serve(8'h41);
    serve(8'h40);
    test_done();
  end
endmodule
